// ==== rtl/acb_regbank.sv ====
// Configuration register bank of a quad converter behind a three-wire serial port.
// Assumes serial pins are synchronous to i_clock and sampled well above the port rate.
`timescale 1ns/1ns
`include "acb_cfg.svh"
module acb_regbank #(
  parameter int NCH = 4
) (
  input  wire logic           i_clock,
  input  wire logic           i_rst,
  input  wire logic           i_spi_cs_n,
  input  wire logic           i_sclk,
  input  wire logic           i_sdio,
  input  wire logic           i_power_down_pin,
  input  wire logic           i_sync_event,
  output logic                o_sdio,
  output logic                o_sdio_oe,
  output logic [NCH-1:0]      o_chan_power_down,
  output logic [NCH-1:0]      o_chan_output_reset,
  output logic [1:0]          o_power_mode,
  output logic                o_datapath_clock_en,
  output logic                o_datapath_reset,
  output logic                o_outputs_enable,
  output logic                o_chop_en,
  output logic                o_lvds_ieee,
  output logic                o_output_invert,
  output logic                o_twos_complement,
  output logic [1:0]          o_termination,
  output logic                o_clock_drive_2x,
  output logic [7:0]          o_serial_output_control,
  output logic [7:0]          o_override_active,
  output logic                o_sdio_pull_down_dis,
  output logic                o_common_mode_reference_pd,
  output logic                o_sync_pulse
);

  acb_pkg::acb_spi_e st_q;
  logic              sclk_q;
  logic [3:0]        cnt_q;
  logic [15:0]       instr_q;
  logic [7:0]        shift_q;
  logic [12:0]       addr_q;
  logic              rd_q;
  logic [7:0]        chan_sel_q, pwr_q, enh_q, omode_q, oadj_q, serctl_q;
  logic [7:0]        ovr_shadow_q, ovr_active_q, uio2_q, uio3_q, sync_q;
  logic [7:0]        chst_q [NCH];
  logic              armed_q;

  // Serial edge detection and the write strobe for a completed data byte.
  wire        sclk_rise = i_sclk & ~sclk_q;
  wire        sclk_fall = ~i_sclk & sclk_q;
  wire        in_data   = (st_q == acb_pkg::ACB_SP_DATA);
  wire        byte_end  = sclk_rise & in_data & (cnt_q == `ACB_DATA_LAST);
  wire        wr_en     = byte_end & ~rd_q;
  wire [7:0]  wr_data   = {shift_q[6:0], i_sdio};
  wire [15:0] instr_nx  = {instr_q[14:0], i_sdio};
  wire        instr_end = sclk_rise & (st_q == acb_pkg::ACB_SP_INSTR) &
                          (cnt_q == `ACB_INSTR_LAST);

  // Address decode, one select per register.
  wire sel_chan = (addr_q == `ACB_A_CHAN_SEL);
  wire sel_pwr  = (addr_q == `ACB_A_PWR);
  wire sel_enh  = (addr_q == `ACB_A_ENH);
  wire sel_om   = (addr_q == `ACB_A_OMODE);
  wire sel_oa   = (addr_q == `ACB_A_OADJ);
  wire sel_ser  = (addr_q == `ACB_A_SERCTL);
  wire sel_chst = (addr_q == `ACB_A_CHST);
  wire sel_xfer = (addr_q == `ACB_A_XFER);
  wire sel_ovr  = (addr_q == `ACB_A_OVR);
  wire sel_uio2 = (addr_q == `ACB_A_UIO2);
  wire sel_uio3 = (addr_q == `ACB_A_UIO3);
  wire sel_sync = (addr_q == `ACB_A_SYNC);
  wire xfer_go  = wr_en & sel_xfer & wr_data[`ACB_B_XFER];

  // Channel status reads back the OR of all selected channels; none selected reads zero.
  logic [7:0] chst_acc [NCH+1];
  assign chst_acc[0] = `ACB_R_ZERO;

  // Per-channel status storage and its drive of the channel outputs.
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      assign chst_acc[ch+1] = chst_acc[ch] | (chan_sel_q[ch] ? chst_q[ch] : `ACB_R_ZERO);
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          chst_q[ch]              <= `ACB_R_ZERO;
          o_chan_power_down[ch]   <= 1'b0;
          o_chan_output_reset[ch] <= 1'b0;
        end else begin
          if (wr_en && sel_chst && chan_sel_q[ch]) begin
            chst_q[ch] <= wr_data & `ACB_M_CHST;
          end
          o_chan_power_down[ch]   <= chst_q[ch][`ACB_B_CH_PD];
          o_chan_output_reset[ch] <= chst_q[ch][`ACB_B_CH_ORST];
        end
      end
    end
  endgenerate

  // Serial port engine. Only i_rst reaches it, so no power mode can lock the host out.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_q      <= acb_pkg::ACB_SP_IDLE;
      sclk_q    <= 1'b0;
      cnt_q     <= `ACB_CNT_ZERO;
      instr_q   <= 16'h0000;
      shift_q   <= `ACB_R_ZERO;
      addr_q    <= 13'h0000;
      rd_q      <= 1'b0;
      o_sdio    <= 1'b0;
      o_sdio_oe <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
      if (i_spi_cs_n) begin
        st_q      <= acb_pkg::ACB_SP_INSTR;
        cnt_q     <= `ACB_CNT_ZERO;
        o_sdio_oe <= 1'b0;
      end else begin
        case (st_q)
          acb_pkg::ACB_SP_INSTR: begin
            if (sclk_rise) begin
              instr_q <= instr_nx;
              cnt_q   <= cnt_q + `ACB_CNT_ONE;
            end
            if (instr_end) begin
              st_q   <= acb_pkg::ACB_SP_DATA;
              addr_q <= instr_nx[12:0];
              rd_q   <= instr_nx[`ACB_B_RW];
            end
          end
          acb_pkg::ACB_SP_DATA: begin
            if (sclk_rise && !rd_q) begin
              shift_q <= wr_data;
            end
            if (sclk_fall && rd_q) begin
              o_sdio    <= shift_q[7];
              o_sdio_oe <= 1'b1;
              shift_q   <= {shift_q[6:0], 1'b0};
            end
            if (sclk_rise) begin
              cnt_q <= cnt_q + `ACB_CNT_ONE;
            end
            if (byte_end) begin
              st_q <= acb_pkg::ACB_SP_DONE;
            end
          end
          acb_pkg::ACB_SP_DONE: begin
            st_q <= acb_pkg::ACB_SP_DONE;
          end
          default: begin
            st_q <= acb_pkg::ACB_SP_INSTR;
          end
        endcase
        if (instr_end && instr_nx[`ACB_B_RW]) begin
          shift_q <= rd_data_at(instr_nx[12:0]);
        end
      end
    end
  end

  // Read data must be taken from the address just shifted in, not the stale one.
  // The transfer strobe and unmapped addresses read as zero.
  function automatic logic [7:0] rd_data_at(input logic [12:0] a);
    rd_data_at = (a == `ACB_A_CHAN_SEL) ? chan_sel_q : (a == `ACB_A_PWR) ? pwr_q :
                 (a == `ACB_A_ENH) ? enh_q : (a == `ACB_A_OMODE) ? omode_q :
                 (a == `ACB_A_OADJ) ? oadj_q : (a == `ACB_A_SERCTL) ? serctl_q :
                 (a == `ACB_A_CHST) ? chst_acc[NCH] : (a == `ACB_A_OVR) ? ovr_shadow_q :
                 (a == `ACB_A_UIO2) ? uio2_q : (a == `ACB_A_UIO3) ? uio3_q :
                 (a == `ACB_A_SYNC) ? sync_q : `ACB_R_ZERO;
  endfunction

  // Configuration storage; global registers ignore the channel selection.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      chan_sel_q   <= `ACB_R_CHAN_SEL;
      pwr_q        <= `ACB_R_ZERO;
      enh_q        <= `ACB_R_ZERO;
      omode_q      <= `ACB_R_OMODE;
      oadj_q       <= `ACB_R_ZERO;
      serctl_q     <= `ACB_R_SERCTL;
      ovr_shadow_q <= `ACB_R_ZERO;
      ovr_active_q <= `ACB_R_ZERO;
      uio2_q       <= `ACB_R_ZERO;
      uio3_q       <= `ACB_R_ZERO;
      sync_q       <= `ACB_R_ZERO;
    end else if (wr_en) begin
      if (sel_chan) chan_sel_q <= wr_data & `ACB_M_CHAN_SEL;
      if (sel_pwr) pwr_q <= wr_data & `ACB_M_PWR;
      if (sel_enh) enh_q <= wr_data & `ACB_M_ENH;
      if (sel_om) omode_q <= wr_data & `ACB_M_OMODE;
      if (sel_oa) oadj_q <= wr_data & `ACB_M_OADJ;
      if (sel_ser) serctl_q <= wr_data & `ACB_M_SERCTL;
      if (sel_ovr) ovr_shadow_q <= wr_data & `ACB_M_OVR;
      if (xfer_go) ovr_active_q <= ovr_shadow_q;
      if (sel_uio2) uio2_q <= wr_data & `ACB_M_UIO2;
      if (sel_uio3) uio3_q <= wr_data & `ACB_M_UIO3;
      if (sel_sync) sync_q <= wr_data & `ACB_M_SYNC;
    end
  end

  // The asserted pin overrides the field, choosing power-down or standby.
  wire [1:0] eff_mode = !i_power_down_pin ? pwr_q[1:0] :
                        pwr_q[`ACB_B_PIN_FN] ? acb_pkg::ACB_PM_PDOWN :
                        acb_pkg::ACB_PM_STANDBY;
  wire clk_en_d = (eff_mode == acb_pkg::ACB_PM_NORMAL) ||
                  (eff_mode == acb_pkg::ACB_PM_DRESET);
  wire dp_rst_d = (eff_mode == acb_pkg::ACB_PM_PDOWN) ||
                  (eff_mode == acb_pkg::ACB_PM_DRESET);
  wire out_en_d = (eff_mode == acb_pkg::ACB_PM_NORMAL);

  // Sync gating: in next-only mode a single event is passed until the register is rewritten.
  wire sync_ok = sync_q[`ACB_B_SYNC_EN] & i_sync_event &
                 (~sync_q[`ACB_B_SYNC_NEXT] | armed_q);

  // Registered outputs so every control leaves the block straight from a flip-flop.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_power_mode               <= acb_pkg::ACB_PM_NORMAL;
      o_datapath_clock_en        <= 1'b1;
      o_datapath_reset           <= 1'b0;
      o_outputs_enable           <= 1'b1;
      o_chop_en                  <= 1'b0;
      o_lvds_ieee                <= 1'b0;
      o_output_invert            <= 1'b0;
      o_twos_complement          <= 1'b1;
      o_termination              <= 2'b00;
      o_clock_drive_2x           <= 1'b0;
      o_serial_output_control    <= `ACB_R_SERCTL;
      o_override_active          <= `ACB_R_ZERO;
      o_sdio_pull_down_dis       <= 1'b0;
      o_common_mode_reference_pd <= 1'b0;
      o_sync_pulse               <= 1'b0;
      armed_q                    <= 1'b1;
    end else begin
      o_power_mode               <= eff_mode;
      o_datapath_clock_en        <= clk_en_d;
      o_datapath_reset           <= dp_rst_d;
      o_outputs_enable           <= out_en_d;
      o_chop_en                  <= enh_q[`ACB_B_CHOP];
      o_lvds_ieee                <= omode_q[`ACB_B_IEEE];
      o_output_invert            <= omode_q[`ACB_B_INVERT];
      o_twos_complement          <= omode_q[`ACB_B_TWOS];
      o_termination              <= oadj_q[`ACB_B_TERM_HI:`ACB_B_TERM_LO];
      o_clock_drive_2x           <= oadj_q[`ACB_B_DRIVE] & (|chan_sel_q[7:`ACB_B_CLK_CH_LO]);
      o_serial_output_control    <= serctl_q;
      o_override_active          <= ovr_active_q;
      o_sdio_pull_down_dis       <= uio2_q[`ACB_B_UIO2_PD];
      o_common_mode_reference_pd <= uio3_q[`ACB_B_UIO3_VCM];
      o_sync_pulse               <= sync_ok;
      if (wr_en && sel_sync) armed_q <= 1'b1; // A rewrite re-arms and beats a same-cycle use.
      else if (sync_ok && sync_q[`ACB_B_SYNC_NEXT]) armed_q <= 1'b0;
    end
  end

  // Checks on the behaviour of the bank.
  imm_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && sel_om) |=> (omode_q == ($past(wr_data) & `ACB_M_OMODE)))
    else $error("output mode write did not apply at once");
  ovr_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && sel_ovr) |=> $stable(ovr_active_q))
    else $error("override went active without transfer");
  ovr_commit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    xfer_go |=> (ovr_active_q == $past(ovr_shadow_q)) ##1 (o_override_active == ovr_active_q))
    else $error("transfer did not commit override");
  chan_mask_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && sel_chst && !chan_sel_q[0]) |=> $stable(chst_q[0]))
    else $error("unselected channel status changed");
  pin_pdown_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_power_down_pin && pwr_q[`ACB_B_PIN_FN]) |=> (o_datapath_reset && !o_datapath_clock_en))
    else $error("pin did not enter power-down");
  pin_standby_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_power_down_pin && !pwr_q[`ACB_B_PIN_FN]) |=>
    (!o_datapath_reset && !o_datapath_clock_en && !o_outputs_enable))
    else $error("pin did not enter standby");
  normal_run_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!i_power_down_pin && pwr_q[1:0] == 2'b00) |=> (o_outputs_enable && o_datapath_clock_en))
    else $error("normal mode not running");
  dig_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!i_power_down_pin && pwr_q[1:0] == 2'b11) |=> (o_datapath_reset && !o_outputs_enable))
    else $error("digital reset not applied");
  port_alive_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_spi_cs_n && o_datapath_reset) |=> (st_q == acb_pkg::ACB_SP_INSTR))
    else $error("serial port not ready in reset mode");
  chop_follow_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && sel_enh) |-> ##2 (o_chop_en == $past(wr_data[`ACB_B_CHOP], 2)))
    else $error("chop enable mismatch");
  invert_fmt_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && sel_om) |-> ##2 ((o_output_invert == $past(wr_data[`ACB_B_INVERT], 2)) &&
    (o_twos_complement == $past(wr_data[`ACB_B_TWOS], 2)) &&
    (o_lvds_ieee == $past(wr_data[`ACB_B_IEEE], 2))))
    else $error("output mode bits mismatch");
  term_sel_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && sel_oa) |-> ##2
    (o_termination == $past(wr_data[`ACB_B_TERM_HI:`ACB_B_TERM_LO], 2)))
    else $error("termination select mismatch");
  sync_once_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (sync_ok && sync_q[`ACB_B_SYNC_NEXT] && !(wr_en && sel_sync)) |=> !sync_ok)
    else $error("second sync honoured in next-only mode");

endmodule

// ==== rtl/acb_cfg.svh ====
// Addresses, field positions, reset values and serial-port counts for the config bank.
// Assumes a 13-bit register address space carried in a 16-bit serial instruction.
`ifndef ACB_CFG_SVH
`define ACB_CFG_SVH
`define ACB_A_CHAN_SEL   13'h0005
`define ACB_A_PWR        13'h0008
`define ACB_A_ENH        13'h000C
`define ACB_A_OMODE      13'h0014
`define ACB_A_OADJ       13'h0015
`define ACB_A_SERCTL     13'h0021
`define ACB_A_CHST       13'h0022
`define ACB_A_XFER       13'h00FF
`define ACB_A_OVR        13'h0100
`define ACB_A_UIO2       13'h0101
`define ACB_A_UIO3       13'h0102
`define ACB_A_SYNC       13'h0109
`define ACB_M_CHAN_SEL   8'h3F
`define ACB_M_PWR        8'h23
`define ACB_M_ENH        8'h04
`define ACB_M_OMODE      8'h45
`define ACB_M_OADJ       8'h31
`define ACB_M_SERCTL     8'hF7
`define ACB_M_CHST       8'h03
`define ACB_M_OVR        8'h77
`define ACB_M_UIO2       8'h01
`define ACB_M_UIO3       8'h08
`define ACB_M_SYNC       8'h03
`define ACB_R_CHAN_SEL   8'h3F
`define ACB_R_ZERO       8'h00
`define ACB_R_OMODE      8'h01
`define ACB_R_SERCTL     8'h32
`define ACB_B_PIN_FN     5
`define ACB_B_CHOP       2
`define ACB_B_IEEE       6
`define ACB_B_INVERT     2
`define ACB_B_TWOS       0
`define ACB_B_TERM_HI    5
`define ACB_B_TERM_LO    4
`define ACB_B_DRIVE      0
`define ACB_B_XFER       0
`define ACB_B_CH_PD      0
`define ACB_B_CH_ORST    1
`define ACB_B_SYNC_EN    0
`define ACB_B_SYNC_NEXT  1
`define ACB_B_UIO2_PD    0
`define ACB_B_UIO3_VCM   3
`define ACB_B_CLK_CH_LO  4
`define ACB_B_RW         15
`define ACB_INSTR_LAST   4'hF
`define ACB_DATA_LAST    4'h7
`define ACB_CNT_ZERO     4'h0
`define ACB_CNT_ONE      4'h1
`endif

// ==== rtl/acb_pkg.sv ====
// Types shared by the configuration register bank.
// Assumes acb_cfg.svh supplies the numeric constants.
package acb_pkg;
  typedef enum logic [1:0] {
    ACB_SP_IDLE  = 2'b00,
    ACB_SP_INSTR = 2'b01,
    ACB_SP_DATA  = 2'b11,
    ACB_SP_DONE  = 2'b10
  } acb_spi_e;
  typedef enum logic [1:0] {
    ACB_PM_NORMAL  = 2'b00,
    ACB_PM_PDOWN   = 2'b01,
    ACB_PM_STANDBY = 2'b10,
    ACB_PM_DRESET  = 2'b11
  } acb_pmode_e;
endpackage

// ==== bench/acb_host_model.sv ====
// Host controller model that drives the three-wire serial port of the config bank.
// Assumes the bench resolves the shared data line and feeds it back on i_sdio_line.
`timescale 1ns/1ns
module acb_host_model (
  input  wire logic i_clock,
  input  wire logic i_sdio_line,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdio,
  output logic      o_drive
);
  // Idle state: deselected, clock parked low, data line driven low.
  initial begin
    o_cs_n  = 1'b1;
    o_sclk  = 1'b0;
    o_sdio  = 1'b0;
    o_drive = 1'b1;
  end

  // One frame of 16 instruction bits and one data byte, MSB first.
  // The low phase is four clocks so the registered read bit has settled before the rise.
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [23:0] w;
    w = {rd, 2'b00, a, d};
    q = 8'h00;
    @(posedge i_clock);
    o_cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_sclk <= 1'b0;
      o_sdio <= w[i];
      if (rd && i < 8) begin
        o_drive <= 1'b0;
      end
      repeat (4) @(posedge i_clock);
      if (i < 8) begin
        q[i] = i_sdio_line;
      end
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clock);
    end
    o_sclk <= 1'b0;
    @(posedge i_clock);
    o_cs_n  <= 1'b1;
    o_drive <= 1'b1;
    repeat (4) @(posedge i_clock);
  endtask
endmodule

// ==== bench/test_adc_config_register_bank.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the serial port and the bench owns the remaining pins.
`timescale 1ns/1ns
`include "acb_cfg.svh"
module test_adc_config_register_bank;
  typedef struct packed {
    logic        wr;
    logic [12:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } acb_row_s;
  logic       i_clock = 1'b0;
  logic       i_rst   = 1'b1;
  logic       pin     = 1'b0;
  logic       ev      = 1'b0;
  logic       tgl     = 1'b0;
  logic       cs_n, sclk, h_sdio, h_drive, d_sdio, d_oe, line;
  logic [3:0] cpd, corst;
  logic [1:0] pmode, term;
  logic       clk_en, dp_rst, out_en, chop, ieee, inv, twos, drv2, pd_dis, vcm_pd, sync_p;
  logic [7:0] soc, ovr, q;
  int         n_fail = 0;
  int         total_checks = 0;
  int         n_sync = 0;
  logic [2:0] pm_exp [4] = '{3'b101, 3'b010, 3'b000, 3'b110};
  acb_row_s   rows [22] = '{
    '{1'b0, 13'h005, 8'h00, 8'h3F}, '{1'b0, 13'h008, 8'h00, 8'h00},
    '{1'b0, 13'h00C, 8'h00, 8'h00}, '{1'b0, 13'h014, 8'h00, 8'h01},
    '{1'b0, 13'h015, 8'h00, 8'h00}, '{1'b0, 13'h021, 8'h00, 8'h32},
    '{1'b0, 13'h022, 8'h00, 8'h00}, '{1'b0, 13'h0FF, 8'h00, 8'h00},
    '{1'b0, 13'h100, 8'h00, 8'h00}, '{1'b0, 13'h101, 8'h00, 8'h00},
    '{1'b0, 13'h102, 8'h00, 8'h00}, '{1'b0, 13'h109, 8'h00, 8'h00},
    '{1'b1, 13'h00C, 8'hFF, 8'h04}, '{1'b1, 13'h014, 8'hFF, 8'h45},
    '{1'b1, 13'h015, 8'hFE, 8'h30}, '{1'b1, 13'h021, 8'hFF, 8'hF7},
    '{1'b1, 13'h101, 8'hFF, 8'h01}, '{1'b1, 13'h102, 8'hFF, 8'h08},
    '{1'b1, 13'h109, 8'hFF, 8'h03}, '{1'b1, 13'h100, 8'hFF, 8'h77},
    '{1'b1, 13'h0FF, 8'h01, 8'h00}, '{1'b1, 13'h007, 8'h5A, 8'h00}};

  // Clock at 250 MHz and a pattern that changes every cycle for an undriven line.
  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) tgl <= ~tgl;
  always @(posedge i_clock) if (sync_p === 1'b1) n_sync++;
  // Shared data line: host, then device, else the pull-down or a floating pattern.
  assign line = h_drive ? h_sdio : (d_oe === 1'b1 ? d_sdio : (pd_dis === 1'b1 ? tgl : 1'b0));

  acb_host_model host (.i_clock(i_clock), .i_sdio_line(line), .o_cs_n(cs_n), .o_sclk(sclk),
                       .o_sdio(h_sdio), .o_drive(h_drive));
  acb_regbank #(.NCH(4)) dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_spi_cs_n(cs_n), .i_sclk(sclk), .i_sdio(line),
    .i_power_down_pin(pin), .i_sync_event(ev), .o_sdio(d_sdio), .o_sdio_oe(d_oe),
    .o_chan_power_down(cpd), .o_chan_output_reset(corst), .o_power_mode(pmode),
    .o_datapath_clock_en(clk_en), .o_datapath_reset(dp_rst), .o_outputs_enable(out_en),
    .o_chop_en(chop), .o_lvds_ieee(ieee), .o_output_invert(inv), .o_twos_complement(twos),
    .o_termination(term), .o_clock_drive_2x(drv2), .o_serial_output_control(soc),
    .o_override_active(ovr), .o_sdio_pull_down_dis(pd_dis),
    .o_common_mode_reference_pd(vcm_pd), .o_sync_pulse(sync_p));

  // Compares one value and counts it; a mismatch is reported at once.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.frame(1'b0, a, d, dummy);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    host.frame(1'b1, a, 8'h00, v);
  endtask
  task automatic pulse_sync();
    @(posedge i_clock) ev <= 1'b1;
    @(posedge i_clock) ev <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // A hang anywhere is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge i_clock);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    // Reset values of every mapped register, access and masks of all but 005, 008 and 022, plus one unmapped place.
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      check("register readback", q, rows[i].e);
    end
    check("output controls", {chop, ieee, inv, twos, term, pd_dis, vcm_pd}, 8'hFF);
    check("serial control", soc, 8'hF7);
    $display("test rows done");
    // Clearing the output bits and setting termination to 01 takes effect without any commit.
    wr(13'h014, 8'h00);
    wr(13'h00C, 8'h00);
    wr(13'h015, 8'h10);
    check("output fields", {chop, ieee, inv, twos, term}, 8'h01);
    // Override stays at the committed value until transfer bit 0 is written high.
    wr(13'h100, 8'h12);
    check("override held", ovr, 8'h77);
    wr(13'h0FF, 8'h00);
    check("override no strobe", ovr, 8'h77);
    wr(13'h0FF, 8'h01);
    check("override commit", ovr, 8'h12);
    $display("test override done");
    // Every power mode, with the serial port still answering in each.
    for (int m = 0; m < 4; m++) begin
      wr(13'h008, 8'(m));
      check("power mode", 8'(pmode), 8'(m));
      check("power controls", 8'({clk_en, dp_rst, out_en}), 8'(pm_exp[m]));
      rd(13'h008, q);
      check("port alive", q, 8'(m));
    end
    wr(13'h008, 8'h20);
    @(posedge i_clock) pin <= 1'b1;
    repeat (3) @(posedge i_clock);
    check("pin power-down", 8'({pmode, clk_en, dp_rst, out_en}), 8'h0A);
    wr(13'h008, 8'h00);
    check("pin standby", 8'({pmode, clk_en, dp_rst, out_en}), 8'h10);
    @(posedge i_clock) pin <= 1'b0;
    repeat (3) @(posedge i_clock);
    $display("test power done");
    // Per-channel writes reach only the selected channels; global ones reach all.
    wr(13'h005, 8'h02);
    wr(13'h022, 8'h01);
    check("chan status", {cpd, corst}, 8'h20);
    wr(13'h005, 8'h0F);
    wr(13'h022, 8'h02);
    check("chan status all", {cpd, corst}, 8'h0F);
    // No channel selected, so a global write must still land; then clock drive with channels 4 and 5 selected.
    wr(13'h005, 8'h00);
    wr(13'h021, 8'h42);
    check("global serial ctl", soc, 8'h42);
    wr(13'h005, 8'h30);
    wr(13'h015, 8'h01);
    check("clock drive", 8'(drv2), 8'h01);
    $display("test channels done");
    // Sync off, every event, next event only.
    wr(13'h109, 8'h00);
    repeat (2) pulse_sync();
    check("sync off", 8'(n_sync), 8'h00);
    wr(13'h109, 8'h01);
    repeat (2) pulse_sync();
    check("sync every", 8'(n_sync), 8'h02);
    wr(13'h109, 8'h03);
    repeat (2) pulse_sync();
    check("sync next only", 8'(n_sync), 8'h03);
    $display("test sync done");
    // A second reset in mid-run restores the defaults.
    @(posedge i_clock) i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    check("reset outputs", {soc[5:0], twos, clk_en}, 8'hCB);
    // Drive, pull-down, reference and channel resets were all set before; read enable was already low.
    check("reset misc", {drv2, vcm_pd, pd_dis, d_oe, corst}, 8'h00);
    i_rst <= 1'b0;
    rd(13'h014, q);
    check("reset readback", q, 8'h01);
    $display("test reset done");
    test_done();
  end
endmodule
